//--- hdl/spm_power_manager.v
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "spm_regs.vh"

module spm_power_manager #(
	parameter [19:0] TICK_CYCLES = `SPM_TICK_CYCLES
)(
	input wire sys_clk,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire inst_above_095,
	input wire inst_above_100,
	input wire inst_above_110,
	input wire avg_above_095,
	input wire avg_above_110,
	input wire above_ramp_down,
	input wire above_060,
	input wire above_shutdown,
	input wire above_lowbat,
	input wire button_in,
	input wire [1:0] mem_sel_in,
	output reg button_press,
	output reg audio_mute,
	output reg [4:0] gain_red_db,
	output reg hw_reset,
	output reg [1:0] mem_restore,
	output reg mem_restore_load,
	output reg lowbat_req,
	output reg [7:0] lowbat_thresh
);
	localparam [1:0] ST_POR = 2'h0;
	localparam [1:0] ST_RUN = 2'h1;
	localparam [1:0] ST_MUTED = 2'h2;
	localparam [1:0] ST_OFF = 2'h3;
	localparam [1:0] Z_MID = 2'h0;
	localparam [1:0] Z_LOW = 2'h1;
	localparam [1:0] Z_HIGH = 2'h2;
	function hit;
		input [`SPM_ADDR_W-1:0] a;
		input [`SPM_ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction
	// pin synchronisers; no reset, so they already track the pins when reset lifts
	wire [9:0] raw_in;
	reg [9:0] meta_q;
	reg [9:0] sync_q;
	assign raw_in = {button_in, above_lowbat, above_shutdown, above_060, above_ramp_down,
		avg_above_110, avg_above_095, inst_above_110, inst_above_100, inst_above_095};
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi = gi + 1)
		begin : g_sync
			always @(posedge sys_clk)
			begin
				meta_q[gi] <= raw_in[gi];
				sync_q[gi] <= meta_q[gi];
			end
		end
	endgenerate
	wire i095 = sync_q[0];
	wire i100 = sync_q[1];
	wire i110 = sync_q[2];
	wire a095 = sync_q[3];
	wire a110 = sync_q[4];
	wire ramp_ok = sync_q[5];
	wire ok060 = sync_q[6];
	wire shut_ok = sync_q[7];
	wire lb_ok = sync_q[8];
	wire btn = sync_q[9];
	// bus slave: zero wait states, always OKAY
	reg [31:0] ctrl_q;
	reg [3:0] por_cfg_q;
	reg [19:0] presc_q;
	reg wr_pend_q;
	reg [`SPM_ADDR_W-1:0] wr_addr_q;
	wire [31:0] status;
	wire [`SPM_ADDR_W-1:0] a_addr = haddr[`SPM_ADDR_W-1:0];
	wire a_valid = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= {`SPM_ADDR_W{1'b0}};
			hrdata <= 32'h0000_0000;
			ctrl_q <= `SPM_CTRL_RESET;
			por_cfg_q <= `SPM_POR_RESET;
			presc_q <= TICK_CYCLES;
		end
		else
		begin
			wr_pend_q <= a_valid & hwrite;
			wr_addr_q <= a_addr;
			if (a_valid & !hwrite)
			begin
				if (hit(a_addr, `SPM_OFF_CTRL))
					hrdata <= {29'h0000_0000, ctrl_q[2:0]};
				else if (hit(a_addr, `SPM_OFF_POR))
					hrdata <= {28'h000_0000, por_cfg_q};
				else if (hit(a_addr, `SPM_OFF_PRESC))
					hrdata <= {12'h000, presc_q};
				else if (hit(a_addr, `SPM_OFF_STATUS))
					hrdata <= status;
				else
					hrdata <= 32'h0000_0000;
			end
			if (wr_pend_q)
			begin
				if (hit(wr_addr_q, `SPM_OFF_CTRL))
					ctrl_q <= {16'h0000, hwdata[15:8], 5'h00, hwdata[2:0]};
				else if (hit(wr_addr_q, `SPM_OFF_POR))
					por_cfg_q <= (hwdata[3:0] > `SPM_POR_MAX_S) ? `SPM_POR_MAX_S : hwdata[3:0];
				else if (hit(wr_addr_q, `SPM_OFF_PRESC))
					presc_q <= hwdata[19:0];
			end
		end
	end
	wire [1:0] mode = ctrl_q[`SPM_CTRL_MODE_LSB+1:`SPM_CTRL_MODE_LSB];
	// undefined mode code falls back to the shallow policy
	wire m_deep = (mode == `SPM_MODE_DEEP);
	wire m_adv = (mode == `SPM_MODE_ADV);
	wire lb_en = ctrl_q[`SPM_CTRL_LOWBAT_EN];
	// tick prescaler and one-second pulse
	reg [19:0] presc_cnt_q;
	reg [9:0] ms_cnt_q;
	reg sec_q;
	wire tick = (presc_cnt_q + 20'h00001 >= presc_q);
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			presc_cnt_q <= 20'h00000;
			ms_cnt_q <= 10'h000;
			sec_q <= 1'b0;
		end
		else
		begin
			presc_cnt_q <= tick ? 20'h00000 : presc_cnt_q + 20'h00001;
			sec_q <= 1'b0;
			if (tick)
			begin
				if (ms_cnt_q + 10'h001 == `SPM_TICKS_PER_SEC)
				begin
					ms_cnt_q <= 10'h000;
					sec_q <= 1'b1;
				end
				else
					ms_cnt_q <= ms_cnt_q + 10'h001;
			end
		end
	end
	// supply policy state machine
	reg [1:0] st_q;
	reg [3:0] por_s_q;
	reg went_low_q;
	reg [1:0] mem_saved_q;
	reg btn_prev_q;
	wire off_cond = m_adv ? !shut_ok : (m_deep ? !ok060 : !ramp_ok);
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st_q <= ST_POR;
			por_s_q <= 4'h0;
			went_low_q <= 1'b0;
			mem_saved_q <= `SPM_MEM_A;
			mem_restore <= `SPM_MEM_A;
			mem_restore_load <= 1'b0;
			btn_prev_q <= 1'b0;
			button_press <= 1'b0;
		end
		else
		begin
			mem_restore_load <= 1'b0;
			btn_prev_q <= btn;
			button_press <= btn & !btn_prev_q & (st_q != ST_POR);
			case (st_q)
				ST_POR:
				begin
					if (por_s_q >= por_cfg_q)
						st_q <= ST_RUN;
					else if (sec_q)
						por_s_q <= por_s_q + 4'h1;
				end
				ST_RUN:
				begin
					mem_saved_q <= mem_sel_in;
					if (off_cond)
					begin
						st_q <= ST_OFF;
						went_low_q <= !ok060;
					end
					else if (!m_adv && !i095)
						st_q <= ST_MUTED;
				end
				ST_MUTED:
				begin
					if (off_cond)
					begin
						st_q <= ST_OFF;
						went_low_q <= !ok060;
					end
					else if (!m_deep && !m_adv && i110)
						st_q <= ST_RUN;
				end
				ST_OFF:
				begin
					if (!ok060)
						went_low_q <= 1'b1;
					if (i110)
					begin
						st_q <= ST_RUN;
						mem_restore_load <= 1'b1;
						if (m_deep || went_low_q || !ok060)
							mem_restore <= `SPM_MEM_A;
						else
							mem_restore <= mem_saved_q;
						went_low_q <= 1'b0;
					end
				end
				default:
					st_q <= ST_POR;
			endcase
		end
	end
	wire adv_run = m_adv & (st_q == ST_RUN);
	// instantaneous cuts: hold-off, then monitoring periods
	reg [1:0] inst_cut_q;
	reg [4:0] per_q;
	reg hold_q;
	reg drop110_q;
	reg drop100_q;
	wire per_end = sec_q & (per_q + 5'h01 == `SPM_STAB_S);
	always @(posedge sys_clk)
	begin
		if (!rst_n || !adv_run)
		begin
			inst_cut_q <= 2'h0;
			per_q <= 5'h00;
			hold_q <= 1'b0;
			drop110_q <= 1'b0;
			drop100_q <= 1'b0;
		end
		else if (inst_cut_q == 2'h0)
		begin
			if (a095 && !i095)
			begin
				inst_cut_q <= 2'h1;
				hold_q <= 1'b1;
				per_q <= 5'h00;
			end
		end
		else if (hold_q)
		begin
			// dips during hold-off are ignored while the supply settles
			if (per_end)
			begin
				per_q <= 5'h00;
				hold_q <= 1'b0;
				drop110_q <= 1'b0;
				drop100_q <= 1'b0;
			end
			else if (sec_q)
				per_q <= per_q + 5'h01;
		end
		else if (inst_cut_q == 2'h1 && a095 && !i095)
		begin
			inst_cut_q <= 2'h2;
			hold_q <= 1'b1;
			per_q <= 5'h00;
		end
		else
		begin
			drop110_q <= drop110_q | !i110;
			drop100_q <= drop100_q | !i100;
			if (per_end)
			begin
				per_q <= 5'h00;
				drop110_q <= 1'b0;
				drop100_q <= 1'b0;
				if (!drop110_q && i110)
					inst_cut_q <= 2'h0;
				else if (inst_cut_q == 2'h2 && !drop100_q && i100)
					inst_cut_q <= 2'h1;
			end
			else if (sec_q)
				per_q <= per_q + 5'h01;
		end
	end
	// average cuts, independent of the instantaneous ones
	reg [4:0] avg_cut_q;
	reg avg_mute_q;
	reg [3:0] step_q;
	reg [1:0] zone_q;
	wire [1:0] zone = !a095 ? Z_LOW : (a110 ? Z_HIGH : Z_MID);
	wire step_end = sec_q & (step_q + 4'h1 == `SPM_STEP_S);
	always @(posedge sys_clk)
	begin
		if (!rst_n || !adv_run)
		begin
			avg_cut_q <= 5'h00;
			avg_mute_q <= 1'b0;
			step_q <= 4'h0;
			zone_q <= Z_MID;
		end
		else
		begin
			zone_q <= zone;
			if (zone != zone_q || zone == Z_MID)
				step_q <= 4'h0;
			else if (zone == Z_HIGH && avg_mute_q)
			begin
				avg_mute_q <= 1'b0;
				step_q <= 4'h0;
			end
			else if (step_end)
			begin
				step_q <= 4'h0;
				if (zone == Z_LOW && avg_cut_q < `SPM_AVG_MAX_STEPS)
				begin
					avg_cut_q <= avg_cut_q + 5'h01;
					if (avg_cut_q + 5'h01 == `SPM_AVG_MAX_STEPS)
						avg_mute_q <= 1'b1;
				end
				else if (zone == Z_HIGH && avg_cut_q != 5'h00)
					avg_cut_q <= avg_cut_q - 5'h01;
			end
			else if (sec_q)
				step_q <= step_q + 4'h1;
		end
	end
	// low battery indicator requests
	reg [8:0] lb_cnt_q;
	reg lb_armed_q;
	wire lb_active = lb_en & !lb_ok & (st_q != ST_OFF);
	always @(posedge sys_clk)
	begin
		if (!rst_n || !lb_active)
		begin
			lb_cnt_q <= 9'h000;
			lb_armed_q <= 1'b0;
			lowbat_req <= 1'b0;
		end
		else
		begin
			lowbat_req <= 1'b0;
			if (!lb_armed_q)
			begin
				lb_armed_q <= 1'b1;
				lowbat_req <= 1'b1;
			end
			else if (sec_q)
			begin
				if (lb_cnt_q + 9'h001 == `SPM_LOWBAT_S)
				begin
					lb_cnt_q <= 9'h000;
					lowbat_req <= 1'b1;
				end
				else
					lb_cnt_q <= lb_cnt_q + 9'h001;
			end
		end
	end
	// registered outputs
	wire [4:0] inst_db = (inst_cut_q == 2'h2) ? (`SPM_INST_STEP_DB + `SPM_INST_STEP_DB) :
		((inst_cut_q == 2'h1) ? `SPM_INST_STEP_DB : 5'h00);
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			audio_mute <= 1'b1;
			gain_red_db <= 5'h00;
			hw_reset <= 1'b0;
			lowbat_thresh <= 8'h00;
		end
		else
		begin
			audio_mute <= (st_q != ST_RUN) | avg_mute_q;
			gain_red_db <= inst_db + avg_cut_q;
			hw_reset <= (st_q == ST_OFF);
			lowbat_thresh <= ctrl_q[15:8];
		end
	end
	assign status = {5'h00, lowbat_req, mem_restore, 3'h0, gain_red_db, 3'h0, avg_cut_q,
		2'h0, inst_cut_q, hw_reset, audio_mute, st_q};
endmodule

//--- hdl/spm_regs.vh
`ifndef SPM_REGS_VH
`define SPM_REGS_VH

`define SPM_ADDR_W 8
`define SPM_OFF_CTRL 8'h00
`define SPM_OFF_POR 8'h04
`define SPM_OFF_PRESC 8'h08
`define SPM_OFF_STATUS 8'h0C

`define SPM_CTRL_MODE_LSB 0
`define SPM_CTRL_LOWBAT_EN 2
`define SPM_CTRL_RESET 32'h0000_0000
`define SPM_POR_RESET 4'h0
`define SPM_POR_MAX_S 4'hB

`define SPM_MODE_SHALLOW 2'h0
`define SPM_MODE_DEEP 2'h1
`define SPM_MODE_ADV 2'h2

`define SPM_ST_STATE_LSB 0
`define SPM_ST_MUTE 2
`define SPM_ST_HWRST 3
`define SPM_ST_INST_LSB 4
`define SPM_ST_AVG_LSB 8
`define SPM_ST_GAIN_LSB 16
`define SPM_ST_MEM_LSB 24
`define SPM_ST_LOWBAT 26

`define SPM_MEM_A 2'h0

`define SPM_CLK_PERIOD_NS 4
`define SPM_TICK_NS 1000000
`define SPM_TICK_CYCLES 20'h3D090
`define SPM_TICKS_PER_SEC 10'h3E8
`define SPM_STAB_S 5'h1E
`define SPM_STEP_S 4'hA
`define SPM_LOWBAT_S 9'h12C
`define SPM_INST_STEP_DB 5'h03
`define SPM_AVG_MAX_STEPS 5'h12

`endif

//--- sim/spm_power_manager_props.sv
`timescale 1ns/1ns
module spm_chk (
	input wire sys_clk,
	input wire rst_n,
	input wire inst_above_110,
	input wire above_060,
	input wire above_lowbat,
	input wire button_press,
	input wire hw_reset,
	input wire mem_restore_load,
	input wire lowbat_req,
	input wire [4:0] gain_red_db
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	AST_GAIN_RANGE: assert property (gain_red_db <= 5'h18)
		else $error("gain cut above six plus eighteen");
	AST_LOWBAT_ONE: assert property (lowbat_req |=> !lowbat_req)
		else $error("battery request longer than one cycle");
	AST_LOWBAT_QUIET: assert property (above_lowbat [*8] |-> !lowbat_req)
		else $error("battery request with good supply");
	AST_BTN_ONE: assert property (button_press |=> !button_press)
		else $error("button event longer than one cycle");
	AST_LOAD_ONE: assert property (mem_restore_load |=> !mem_restore_load)
		else $error("restore load longer than one cycle");
	AST_DEAD_OFF: assert property ((!above_060) [*8] |-> hw_reset)
		else $error("no hardware reset below lowest level");
	AST_OFF_HOLD: assert property ((!inst_above_110) [*6] ##0 hw_reset |=> hw_reset)
		else $error("left off state below turn-on level");
	AST_ON_CAUSE: assert property ($fell(hw_reset) |-> inst_above_110 && $past(inst_above_110, 3))
		else $error("restart without turn-on level");
endmodule
bind spm_power_manager spm_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.inst_above_110(inst_above_110), .above_060(above_060), .above_lowbat(above_lowbat),
	.button_press(button_press), .hw_reset(hw_reset), .mem_restore_load(mem_restore_load),
	.lowbat_req(lowbat_req), .gain_red_db(gain_red_db));

//--- sim/spm_supply_model.sv
`timescale 1ns/1ns
module spm_supply_model #(
	parameter [15:0] RAMP_MV = 16'h0320,
	parameter [15:0] SHUT_MV = 16'h0320,
	parameter [15:0] LOWBAT_MV = 16'h041A
)(
	input wire [15:0] inst_mv,
	input wire [15:0] avg_mv,
	output wire inst_above_095,
	output wire inst_above_100,
	output wire inst_above_110,
	output wire avg_above_095,
	output wire avg_above_110,
	output wire above_ramp_down,
	output wire above_060,
	output wire above_shutdown,
	output wire above_lowbat
);
	// comparators are always driven, levels in millivolts
	assign inst_above_095 = inst_mv > 16'h03B6;
	assign inst_above_100 = inst_mv > 16'h03E8;
	assign inst_above_110 = inst_mv > 16'h044C;
	assign avg_above_095 = avg_mv > 16'h03B6;
	assign avg_above_110 = avg_mv > 16'h044C;
	assign above_ramp_down = inst_mv > RAMP_MV;
	assign above_060 = inst_mv > 16'h0258;
	assign above_shutdown = inst_mv > SHUT_MV;
	assign above_lowbat = inst_mv > LOWBAT_MV;
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ns
`include "spm_regs.vh"
module tb_top;
	reg sys_clk = 1'b0;
	reg rst_n = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [2:0] hsize = 3'h2;
	reg [31:0] hwdata = 32'h0;
	reg button_in = 1'b0;
	reg [1:0] mem_sel_in = 2'h0;
	reg [15:0] inst_mv = 16'h04B0;
	reg [15:0] avg_mv = 16'h04B0;
	wire hreadyout, hresp, button_press, audio_mute, hw_reset, mem_restore_load, lowbat_req;
	wire [31:0] hrdata;
	wire [4:0] gain_red_db;
	wire [1:0] mem_restore;
	wire [7:0] lowbat_thresh;
	wire i095, i100, i110, a095, a110, ramp, v060, shut, lowb;
	integer error_cnt = 0;
	integer samples_checked = 0;
	integer lb_cnt = 0;
	integer seed = 32'h7124F277;
	reg [31:0] rd;
	reg [1:0] ms;
	reg [7:0] thr;
	initial forever #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (lowbat_req === 1'b1) lb_cnt <= lb_cnt + 1;
	spm_power_manager #(.TICK_CYCLES(20'h00001)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .inst_above_095(i095), .inst_above_100(i100), .inst_above_110(i110),
		.avg_above_095(a095), .avg_above_110(a110), .above_ramp_down(ramp), .above_060(v060),
		.above_shutdown(shut), .above_lowbat(lowb), .button_in(button_in),
		.mem_sel_in(mem_sel_in), .button_press(button_press), .audio_mute(audio_mute),
		.gain_red_db(gain_red_db), .hw_reset(hw_reset), .mem_restore(mem_restore),
		.mem_restore_load(mem_restore_load), .lowbat_req(lowbat_req),
		.lowbat_thresh(lowbat_thresh));
	spm_supply_model u_sup (.inst_mv(inst_mv), .avg_mv(avg_mv), .inst_above_095(i095),
		.inst_above_100(i100), .inst_above_110(i110), .avg_above_095(a095),
		.avg_above_110(a110), .above_ramp_down(ramp), .above_060(v060),
		.above_shutdown(shut), .above_lowbat(lowb));
	task check(input [31:0] seen, input [31:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task complete_run;
	begin
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	function [31:0] probe(input integer k);
		case (k)
			0: probe = {31'h0, audio_mute};
			1: probe = {31'h0, hw_reset};
			2: probe = {27'h0, gain_red_db};
			3: probe = {31'h0, button_press};
			default: probe = {31'h0, mem_restore_load};
		endcase
	endfunction
	function [31:0] gain_exp(input integer ic, input integer ac);
		gain_exp = ic * `SPM_INST_STEP_DB + ac;
	endfunction
	task wait_for(input integer k, input [31:0] exp, input integer n);
		integer i;
	begin
		i = 0;
		while (probe(k) !== exp && i < n)
		begin
			@(posedge sys_clk);
			#1;
			i = i + 1;
		end
		check(probe(k), exp);
		if (probe(k) !== exp)
			complete_run;
	end
	endtask
	task stay(input integer k, input [31:0] exp, input integer n);
	begin
		repeat (n) @(posedge sys_clk);
		#1;
		check(probe(k), exp);
	end
	endtask
	// zero-wait slave, but the loop keeps a stalled bus from hanging the run
	task bus(input w, input [31:0] a, input [31:0] d);
		integer i;
	begin
		i = 0;
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1 && i < 64)
		begin
			@(posedge sys_clk);
			i = i + 1;
		end
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1 && i < 64)
		begin
			@(posedge sys_clk);
			i = i + 1;
		end
		rd = hrdata;
		if (i >= 64)
			wait_for(0, 2, 0);
	end
	endtask
	task supply(input [15:0] i, input [15:0] a);
	begin
		@(posedge sys_clk);
		inst_mv <= i;
		avg_mv <= a;
	end
	endtask
	initial
	begin
		repeat (19) @(posedge sys_clk);
		#1;
		check(audio_mute, 1'b1);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		wait_for(0, 0, 1100);
		bus(0, `SPM_OFF_PRESC, 0);
		check(rd, 32'h1);
		bus(0, `SPM_OFF_CTRL, 0);
		check(rd, `SPM_CTRL_RESET);
		bus(0, 32'h10, 0);
		check(rd, 32'h0);
		check({hreadyout, hresp}, 32'h2);
		bus(1, `SPM_OFF_POR, 32'hF);
		bus(0, `SPM_OFF_POR, 0);
		check(rd, {28'h0, `SPM_POR_MAX_S});
		@(posedge sys_clk);
		button_in <= 1'b1;
		wait_for(3, 1, 20);
		@(posedge sys_clk);
		button_in <= 1'b0;
		$display("test basic ended");
		rd = $random(seed);
		thr = rd[7:0];
		rd = {$random(seed)} % 3 + 1;
		ms = rd[1:0];
		mem_sel_in <= ms;
		bus(1, `SPM_OFF_CTRL, {16'h0, thr, 8'h04});
		stay(0, 0, 2);
		check(lowbat_thresh, thr);
		supply(16'h0384, 16'h0384);
		wait_for(0, 1, 40);
		supply(16'h03E8, 16'h03E8);
		stay(0, 1, 40);
		supply(16'h047E, 16'h047E);
		wait_for(0, 0, 40);
		supply(16'h02BC, 16'h02BC);
		wait_for(1, 1, 40);
		supply(16'h03E8, 16'h03E8);
		stay(1, 1, 40);
		supply(16'h047E, 16'h047E);
		wait_for(4, 1, 40);
		check(mem_restore, ms);
		wait_for(1, 0, 40);
		supply(16'h01F4, 16'h01F4);
		wait_for(1, 1, 40);
		supply(16'h047E, 16'h047E);
		wait_for(4, 1, 40);
		check(mem_restore, `SPM_MEM_A);
		check(lb_cnt != 0, 1);
		$display("test shallow ended");
		bus(1, `SPM_OFF_CTRL, {16'h0, thr, 8'h05});
		supply(16'h0384, 16'h0384);
		wait_for(0, 1, 40);
		supply(16'h02BC, 16'h02BC);
		stay(1, 0, 40);
		check(audio_mute, 1'b1);
		supply(16'h01F4, 16'h01F4);
		wait_for(1, 1, 40);
		supply(16'h03E8, 16'h03E8);
		stay(1, 1, 40);
		supply(16'h047E, 16'h047E);
		wait_for(4, 1, 40);
		check(mem_restore, `SPM_MEM_A);
		wait_for(0, 0, 40);
		$display("test deep ended");
		bus(1, `SPM_OFF_CTRL, {16'h0, thr, 8'h02});
		supply(16'h0384, 16'h04B0);
		wait_for(2, gain_exp(1, 0), 40);
		supply(16'h04B0, 16'h04B0);
		supply(16'h0384, 16'h04B0);
		stay(2, gain_exp(1, 0), 40);
		supply(16'h04B0, 16'h0384);
		wait_for(2, gain_exp(1, 1), 10500);
		supply(16'h04B0, 16'h03E8);
		stay(2, gain_exp(1, 1), 10500);
		supply(16'h04B0, 16'h04B0);
		wait_for(2, gain_exp(1, 0), 10500);
		wait_for(2, gain_exp(0, 0), 45000);
		check(audio_mute, 1'b0);
		$display("test advanced ended");
		supply(16'h02BC, 16'h04B0);
		wait_for(1, 1, 40);
		supply(16'h047E, 16'h047E);
		wait_for(4, 1, 40);
		check(mem_restore, ms);
		wait_for(0, 0, 40);
		$display("test advanced reset ended");
		complete_run;
	end
endmodule
